// *** tpg_top.sv ***
// three port gpio block with apb register access
`include "tpg_defines.svh"

// What this block does
// R01 - second port direction bit one puts that pin driver in high impedance
// R02 - second port direction bit zero drives the pin from its output latch
// R03 - second port has eight pins, each with its own direction bit
// R04 - option bit 7 cleared enables all second port weak pull-ups together
// R05 - pull-up is off on any second port pin set as output
// R06 - option register resets to all ones, so pull-ups start disabled
// R07 - change detection covers only second port bits 4 to 7 set as inputs
// R08 - inputs compared with last-read reference; mismatches ORed into flag bit 0
// R09 - the port change event can wake the device from sleep
// R10 - any read or write of second port data refreshes the reference
// R11 - mismatch keeps setting the flag; end it before clearing the flag
// R12 - software should not poll the second port while using change detection
// R13 - third port has eight pins with the same direction behaviour
// R14 - enabled peripherals may force third port pins to output or input
// R15 - software avoids read-modify-write on third port direction under override
// R16 - first port bit 4 is timer clock input and open-drain output only
// R17 - first port bit 5 is serial slave select and analog input
// R18 - second port bit 0 is external interrupt; bits 6,7 programming clock/data
// R19 - data reads return live pin levels; writes update only the latch
// R20 - analog config selects analog or digital; analog pins read zero
// R21 - first port upper two data and direction bits read zero, ignore writes
module tpg_top #(
    parameter bit HAS_ANALOG = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // first port
    input wire logic [5:0] first_port_in,
    output tpg_pkg::tpg_pad_type first_port_pad,
    output logic [5:0] first_port_analog_sel,
    // second port
    input wire logic [7:0] second_port_in,
    output tpg_pkg::tpg_pad_type second_port_pad,
    output logic [7:0] second_port_pullup_en,
    // third port
    input wire logic [7:0] third_port_in,
    output tpg_pkg::tpg_pad_type third_port_pad,
    // peripheral overrides
    input wire logic [7:0] periph_force_out,
    input wire logic [7:0] periph_force_in,
    input wire logic [7:0] periph_out_data,
    // alternate functions
    input wire logic prog_mode,
    output logic timer_zero_ext_clock,
    output logic slave_select_n,
    output logic ext_interrupt_in,
    output logic prog_clock,
    output logic prog_data,
    output logic port_change_flag,
    output logic wake_request
);
    import tpg_pkg::*;

    // ****************************************
    // register state
    // ****************************************
    logic [5:0] first_data_q;
    logic [5:0] first_data_d;

    logic [5:0] first_dir_q;
    logic [5:0] first_dir_d;

    logic [7:0] second_data_q;
    logic [7:0] second_data_d;

    logic [7:0] second_dir_q;
    logic [7:0] second_dir_d;

    logic [7:0] third_data_q;
    logic [7:0] third_data_d;

    logic [7:0] third_dir_q;
    logic [7:0] third_dir_d;

    logic [7:0] option_q;
    logic [7:0] option_d;

    logic [2:0] analog_cfg_q;
    logic [2:0] analog_cfg_d;

    logic change_en_q;
    logic change_en_d;

    logic [31:0] prdata_q;
    logic [31:0] prdata_d;

    // decode
    tpg_reg_sel_type sel;
    logic setup_phase;
    logic wr_done;
    logic rd_done;
    // read path
    logic [7:0] rd_value;
    // directions
    logic [7:0] third_dir_eff;
    logic [7:0] first_dir_eff;
    logic [7:0] second_dir_eff;
    logic [7:0] first_read;
    // change event
    logic change_mismatch;
    logic change_flag;
    logic all_digital;
    logic analog_config_sel2;

    // ****************************************
    // address decode
    // ****************************************
    function automatic tpg_reg_sel_type decode(input logic [11:0] addr, input bit analog);
        logic [7:0] idx;
        // index in bits 9:2
        idx = addr[9:2];
        decode = TPG_SEL_NONE;
        if ((addr[11:10] == 2'b00) && (addr[1:0] == 2'b00)) begin
            unique case (idx)
                `TPG_IDX_FIRST_DATA: decode = TPG_SEL_FIRST_DATA;
                `TPG_IDX_SECOND_DATA: decode = TPG_SEL_SECOND_DATA;
                `TPG_IDX_THIRD_DATA: decode = TPG_SEL_THIRD_DATA;
                `TPG_IDX_INT_CTRL: decode = TPG_SEL_INT_CTRL;
                `TPG_IDX_OPTION: decode = TPG_SEL_OPTION;
                `TPG_IDX_FIRST_DIR: decode = TPG_SEL_FIRST_DIR;
                `TPG_IDX_SECOND_DIR: decode = TPG_SEL_SECOND_DIR;
                `TPG_IDX_THIRD_DIR: decode = TPG_SEL_THIRD_DIR;
                `TPG_IDX_ANALOG_CFG: decode = analog ? TPG_SEL_ANALOG_CFG : TPG_SEL_NONE;
                default: decode = TPG_SEL_NONE;
            endcase
        end
    endfunction

    assign sel = decode(paddr, HAS_ANALOG);
    assign setup_phase = psel & ~penable;
    assign wr_done = psel & penable & pwrite & (sel != TPG_SEL_NONE);
    assign rd_done = psel & penable & ~pwrite;

    // ****************************************
    // apb answer
    // ****************************************
    // one wait-free access: read data is captured in the setup cycle
    assign pready = psel & penable;
    // unmapped or misaligned: error
    assign pslverr = psel & penable & (sel == TPG_SEL_NONE);
    assign prdata = prdata_q;

    // ****************************************
    // analog selection
    // ****************************************
    assign analog_config_sel2 = analog_cfg_q[2];
    // codes 6 and 7: all digital
    assign all_digital = analog_config_sel2 & analog_cfg_q[1];

    always_comb begin
        first_port_analog_sel = 6'h00;
        if (HAS_ANALOG && !all_digital) begin
            // bit 4 carries the timer clock and is never analog
            first_port_analog_sel = 6'b10_1111; // R17 R20
        end
        // analog pins read as zero on the digital path
        first_read = {2'b00, first_port_in & ~first_port_analog_sel}; // R20 R21
    end

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        rd_value = 8'h00;
        unique case (sel)
            TPG_SEL_FIRST_DATA: rd_value = first_read; // R19
            TPG_SEL_SECOND_DATA: rd_value = second_port_in; // R19
            TPG_SEL_THIRD_DATA: rd_value = third_port_in; // R19
            TPG_SEL_INT_CTRL: begin
                rd_value[`TPG_CHANGE_FLAG_BIT] = change_flag;
                rd_value[`TPG_CHANGE_ENABLE_BIT] = change_en_q;
            end
            TPG_SEL_OPTION: rd_value = option_q;
            TPG_SEL_FIRST_DIR: rd_value = {2'b00, first_dir_q}; // R21
            TPG_SEL_SECOND_DIR: rd_value = second_dir_q;
            // overridden bits show the effective direction, not the stored one
            TPG_SEL_THIRD_DIR: rd_value = third_dir_eff; // R15
            TPG_SEL_ANALOG_CFG: rd_value = {5'b0_0000, analog_cfg_q};
            TPG_SEL_NONE: rd_value = 8'h00;
        endcase

        // held until the next read
        prdata_d = prdata_q;
        if (setup_phase && !pwrite) begin
            prdata_d = {24'h00_0000, rd_value};
        end
    end

    // ****************************************
    // register writes
    // ****************************************
    always_comb begin
        first_data_d = first_data_q;
        first_dir_d = first_dir_q;
        second_data_d = second_data_q;
        second_dir_d = second_dir_q;
        third_data_d = third_data_q;
        third_dir_d = third_dir_q;
        option_d = option_q;
        analog_cfg_d = analog_cfg_q;
        change_en_d = change_en_q;
        // mapped writes only
        if (wr_done) begin
            unique case (sel)
                TPG_SEL_FIRST_DATA: first_data_d = pwdata[5:0]; // R19 R21
                TPG_SEL_SECOND_DATA: second_data_d = pwdata[7:0]; // R19
                TPG_SEL_THIRD_DATA: third_data_d = pwdata[7:0]; // R19
                TPG_SEL_INT_CTRL: change_en_d = pwdata[`TPG_CHANGE_ENABLE_BIT];
                TPG_SEL_OPTION: option_d = pwdata[7:0]; // R04
                TPG_SEL_FIRST_DIR: first_dir_d = pwdata[5:0]; // R21
                TPG_SEL_SECOND_DIR: second_dir_d = pwdata[7:0]; // R03
                TPG_SEL_THIRD_DIR: third_dir_d = pwdata[7:0]; // R13
                TPG_SEL_ANALOG_CFG: analog_cfg_d = pwdata[2:0]; // R20
                TPG_SEL_NONE: first_data_d = first_data_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // pins start as inputs
            first_data_q <= 6'(`TPG_RST_LATCH);
            first_dir_q <= `TPG_RST_FIRST_DIR;
            second_data_q <= `TPG_RST_LATCH;
            second_dir_q <= `TPG_RST_SECOND_DIR;
            third_data_q <= `TPG_RST_LATCH;
            third_dir_q <= `TPG_RST_THIRD_DIR;
            option_q <= `TPG_RST_OPTION; // R06
            analog_cfg_q <= `TPG_RST_ANALOG_CFG; // R20
            change_en_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            first_data_q <= first_data_d;
            first_dir_q <= first_dir_d;
            second_data_q <= second_data_d;
            second_dir_q <= second_dir_d;
            third_data_q <= third_data_d;
            third_dir_q <= third_dir_d;
            option_q <= option_d;
            analog_cfg_q <= analog_cfg_d;
            change_en_q <= change_en_d;
            prdata_q <= prdata_d;
        end
    end

    // ****************************************
    // pin drivers
    // ****************************************
    // no first port bits 7:6
    assign first_port_pad.out[7:6] = 2'b00;
    assign first_port_pad.oe_n[7:6] = 2'b11;
    assign first_dir_eff[7:6] = 2'b11;

    generate
        for (genvar i = 0; i < 8; i++) begin : g_pin
            // bit 4 is open drain
            if (i < 6) begin : g_first
                tpg_pin_slice u_first (
                    .dir_bit(first_dir_q[i]),
                    .latch_bit(first_data_q[i]),
                    .force_out(1'b0),
                    .force_in(1'b0),
                    .periph_bit(1'b0),
                    .open_drain(i == `TPG_TIMER_CLOCK_BIT), // R16
                    .pin_out(first_port_pad.out[i]),
                    .pin_oe_n(first_port_pad.oe_n[i]),
                    .dir_eff(first_dir_eff[i])
                );
            end

            // second port
            tpg_pin_slice u_second (
                .dir_bit(second_dir_q[i]), // R01 R02 R03
                .latch_bit(second_data_q[i]),
                .force_out(1'b0),
                .force_in(1'b0),
                .periph_bit(1'b0),
                .open_drain(1'b0),
                .pin_out(second_port_pad.out[i]),
                .pin_oe_n(second_port_pad.oe_n[i]),
                .dir_eff(second_dir_eff[i])
            );

            // third port: overrides
            tpg_pin_slice u_third (
                .dir_bit(third_dir_q[i]), // R13
                .latch_bit(third_data_q[i]),
                .force_out(periph_force_out[i]), // R14
                .force_in(periph_force_in[i]), // R14
                .periph_bit(periph_out_data[i]),
                .open_drain(1'b0),
                .pin_out(third_port_pad.out[i]),
                .pin_oe_n(third_port_pad.oe_n[i]),
                .dir_eff(third_dir_eff[i])
            );
        end
    endgenerate

    // one global enable, but never on a driven output
    assign second_port_pullup_en = {8{~option_q[`TPG_PULLUP_DISABLE_N_BIT]}} & second_dir_eff; // R04 R05

    // ****************************************
    // change detection
    // ****************************************
    // polling the port refreshes the reference and can hide a change
    tpg_change_detect u_change (
        .pclk(pclk),
        .presetn(presetn),
        .pins(second_port_in[7:4]),
        .dir(second_dir_q[7:4]), // R07
        .refresh((rd_done | wr_done) && (sel == TPG_SEL_SECOND_DATA)), // R10 R12
        .flag_write(wr_done && (sel == TPG_SEL_INT_CTRL)), // R11
        .flag_wval(pwdata[`TPG_CHANGE_FLAG_BIT]),
        .mismatch(change_mismatch),
        .flag(change_flag)
    );


    // levels until cleared
    assign port_change_flag = change_flag; // R08
    assign wake_request = change_flag & change_en_q; // R09

    // ****************************************
    // alternate functions
    // ****************************************
    // taps on live pin levels
    assign timer_zero_ext_clock = first_port_in[`TPG_TIMER_CLOCK_BIT]; // R16
    assign slave_select_n = first_port_in[`TPG_SLAVE_SELECT_BIT]; // R17
    assign ext_interrupt_in = second_port_in[0]; // R18
    // low outside programming mode
    assign prog_clock = prog_mode & second_port_in[6]; // R18
    assign prog_data = prog_mode & second_port_in[7]; // R18
endmodule

// *** tpg_defines.svh ***
// register indices, field positions and reset values of the three port gpio block
`ifndef TPG_DEFINES_SVH
`define TPG_DEFINES_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define TPG_IDX_FIRST_DATA 8'h05
`define TPG_IDX_SECOND_DATA 8'h06
`define TPG_IDX_THIRD_DATA 8'h07
`define TPG_IDX_INT_CTRL 8'h0b
`define TPG_IDX_OPTION 8'h81
`define TPG_IDX_FIRST_DIR 8'h85
`define TPG_IDX_SECOND_DIR 8'h86
`define TPG_IDX_THIRD_DIR 8'h87
`define TPG_IDX_ANALOG_CFG 8'h9f

// ****************************************
// field positions
// ****************************************
`define TPG_PULLUP_DISABLE_N_BIT 7
`define TPG_CHANGE_FLAG_BIT 0
`define TPG_CHANGE_ENABLE_BIT 3
`define TPG_TIMER_CLOCK_BIT 4
`define TPG_SLAVE_SELECT_BIT 5

// ****************************************
// reset values
// ****************************************
`define TPG_RST_OPTION 8'hff
`define TPG_RST_FIRST_DIR 6'h3f
`define TPG_RST_SECOND_DIR 8'hff
`define TPG_RST_THIRD_DIR 8'hff
`define TPG_RST_ANALOG_CFG 3'h0
`define TPG_RST_LATCH 8'h00

`endif

// *** tpg_pkg.sv ***
// types shared by the three port gpio block
package tpg_pkg;

    // ****************************************
    // pad carrier: output level and active-low enable
    // ****************************************
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } tpg_pad_type;

    // ****************************************
    // register decode
    // ****************************************
    typedef enum logic [3:0] {
        TPG_SEL_NONE,
        TPG_SEL_FIRST_DATA,
        TPG_SEL_SECOND_DATA,
        TPG_SEL_THIRD_DATA,
        TPG_SEL_INT_CTRL,
        TPG_SEL_OPTION,
        TPG_SEL_FIRST_DIR,
        TPG_SEL_SECOND_DIR,
        TPG_SEL_THIRD_DIR,
        TPG_SEL_ANALOG_CFG
    } tpg_reg_sel_type;

endpackage

// *** tpg_pin_slice.sv ***
// one pin: direction override, open-drain option and pad drive
module tpg_pin_slice (
    input wire logic dir_bit,
    input wire logic latch_bit,
    input wire logic force_out,
    input wire logic force_in,
    input wire logic periph_bit,
    input wire logic open_drain,
    output logic pin_out,
    output logic pin_oe_n,
    output logic dir_eff
);
    import tpg_pkg::*;

    always_comb begin
        // a forcing peripheral wins over the stored direction bit
        if (force_out) begin
            dir_eff = 1'b0;
        end else if (force_in) begin
            dir_eff = 1'b1;
        end else begin
            dir_eff = dir_bit;
        end
        pin_out = open_drain ? 1'b0 : (force_out ? periph_bit : latch_bit);
        // open drain only pulls low, never drives high
        pin_oe_n = dir_eff | (open_drain & latch_bit);
    end
endmodule

// *** tpg_change_detect.sv ***
// change detection on the upper four pins of the second port
module tpg_change_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] pins,
    input wire logic [3:0] dir,
    input wire logic refresh,
    input wire logic flag_write,
    input wire logic flag_wval,
    output logic mismatch,
    output logic flag
);
    import tpg_pkg::*;

    logic [3:0] ref_d;
    logic [3:0] ref_q;
    logic flag_d;
    logic flag_q;

    always_comb begin
        // only input pins take part in the comparison
        mismatch = |((pins ^ ref_q) & dir); // R07 R08
        ref_d = refresh ? pins : ref_q; // R10
        // a standing mismatch beats a clear in the same cycle
        flag_d = mismatch | (flag_write ? flag_wval : flag_q); // R11
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q <= 4'h0;
            flag_q <= 1'b0;
        end else begin
            ref_q <= ref_d;
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule

// *** tpg_top_monitor.sv ***
// checker for the three port gpio block, bound to its top module
`include "tpg_defines.svh"
module tpg_top_monitor #(
    parameter bit HAS_ANALOG = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] first_port_in,
    input wire tpg_pkg::tpg_pad_type first_port_pad,
    input wire logic [5:0] first_port_analog_sel,
    input wire tpg_pkg::tpg_pad_type second_port_pad,
    input wire logic [7:0] second_port_pullup_en,
    input wire logic timer_zero_ext_clock,
    input wire logic slave_select_n,
    input wire logic port_change_flag,
    input wire logic wake_request
);
    import tpg_pkg::*;
    // ****
    // assertions
    // ****
    logic int_wr;
    logic dat_wr;
    assign int_wr = psel & penable & pwrite & (paddr == {2'b00, `TPG_IDX_INT_CTRL, 2'b00});
    assign dat_wr = psel & penable & pwrite & (paddr == {2'b00, `TPG_IDX_SECOND_DATA, 2'b00});
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PULLUP_OUTPUT_OFF: assert property (
        (second_port_pullup_en & ~second_port_pad.oe_n) == 8'h00) else $error("pull-up on a driven pin");
    AST_PULLUP_RESET: assert property (
        $rose(presetn) |-> second_port_pullup_en == 8'h00) else $error("pull-ups on after reset");
    AST_OPEN_DRAIN: assert property (
        first_port_pad.out[4] == 1'b0) else $error("timer clock pin drives high");
    AST_FIRST_UPPER: assert property (
        first_port_pad.oe_n[7:6] == 2'b11 && first_port_pad.out[7:6] == 2'b00) else $error("upper pins driven");
    AST_TIMER_CLOCK: assert property (
        timer_zero_ext_clock == first_port_in[4]) else $error("timer clock not from pin 4");
    AST_SLAVE_SELECT: assert property (
        slave_select_n == first_port_in[5]) else $error("slave select not from pin 5");
    AST_FLAG_CLEAR: assert property (
        $fell(port_change_flag) |-> $past(int_wr)) else $error("flag fell without a write");
    AST_LATCH_WRITE: assert property (
        !$stable(second_port_pad.out) |-> $past(dat_wr)) else $error("latch changed without a write");
    AST_WAKE_FLAG: assert property (
        wake_request |-> port_change_flag) else $error("wake without flag");
    AST_ANALOG_RESET: assert property (
        $rose(presetn) |-> !HAS_ANALOG || first_port_analog_sel == 6'h2f) else $error("pins not analog at reset");
    AST_READY: assert property (psel && penable |-> pready) else $error("no ready");
    cover property ($rose(port_change_flag));
    cover property (wake_request);
    cover property (pslverr);
endmodule
bind tpg_top tpg_top_monitor #(.HAS_ANALOG(HAS_ANALOG)) tpg_top_monitor_i (.*);

// *** tpg_pin_model.sv ***
// external circuits seen at the three ports
module tpg_pin_model (
    input wire tpg_pkg::tpg_pad_type pad1,
    input wire tpg_pkg::tpg_pad_type pad2,
    input wire tpg_pkg::tpg_pad_type pad3,
    input wire logic [7:0] pullup_en,
    input wire logic [7:0] ext1,
    input wire logic [7:0] ext2,
    input wire logic [7:0] ext3,
    output logic [5:0] lvl1,
    output logic [7:0] lvl2,
    output logic [7:0] lvl3
);
    import tpg_pkg::*;
    logic [7:0] l1;
    // released pins show the pull-up or the random outside level, never the old drive
    function automatic logic [7:0] lvl(input tpg_pad_type p, input logic [7:0] pu, input logic [7:0] x);
        return (~p.oe_n & p.out) | (p.oe_n & pu) | (p.oe_n & ~pu & x);
    endfunction
    assign l1 = lvl(pad1, 8'h00, ext1);
    assign lvl1 = l1[5:0];
    assign lvl2 = lvl(pad2, pullup_en, ext2);
    assign lvl3 = lvl(pad3, 8'h00, ext3);
endmodule

// *** testbench.sv ***
// self-checking testbench of the three port gpio block
`include "tpg_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tpg_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, prog_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [5:0] first_port_in, first_port_analog_sel;
    logic [7:0] second_port_in, third_port_in, second_port_pullup_en, pfo, pfi, pod;
    tpg_pad_type first_port_pad, second_port_pad, third_port_pad;
    logic tclk, ssn, eint, pclk_o, pdat_o, port_change_flag, wake_request;
    logic [7:0] ext1, ext2, ext3, d, l, o, eff, v;
    logic [32:0] e, exp_q[$];
    int mismatches = 0;
    int total_checks = 0;
    tpg_top tpg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .first_port_in(first_port_in), .first_port_pad(first_port_pad),
        .first_port_analog_sel(first_port_analog_sel), .second_port_in(second_port_in),
        .second_port_pad(second_port_pad), .second_port_pullup_en(second_port_pullup_en),
        .third_port_in(third_port_in), .third_port_pad(third_port_pad), .periph_force_out(pfo),
        .periph_force_in(pfi), .periph_out_data(pod), .prog_mode(prog_mode), .timer_zero_ext_clock(tclk),
        .slave_select_n(ssn), .ext_interrupt_in(eint), .prog_clock(pclk_o), .prog_data(pdat_o),
        .port_change_flag(port_change_flag), .wake_request(wake_request));
    tpg_pin_model tpg_pin_model_i (.pad1(first_port_pad), .pad2(second_port_pad), .pad3(third_port_pad),
        .pullup_en(second_port_pullup_en), .ext1(ext1), .ext2(ext2), .ext3(ext3),
        .lvl1(first_port_in), .lvl2(second_port_in), .lvl3(third_port_in));
    // ****
    // bus tasks and checks
    // ****
    task check(input string nm, input logic [31:0] ex, input logic [31:0] got);
        total_checks++;
        if (got !== ex) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task acc(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] ex);
        exp_q.push_back(ex);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] wd);
        acc(1'b1, {2'b00, idx, 2'b00}, {24'h00_0000, wd}, 33'h0_0000_0000);
    endtask
    task rd(input logic [7:0] idx, input logic [7:0] ex);
        acc(1'b0, {2'b00, idx, 2'b00}, 32'h0000_0000, {25'h000_0000, ex});
    endtask
    // flag is registered one edge after the mismatch, so two edges are enough
    task flag_is(input logic f, input logic w);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check("port_change_flag", f, port_change_flag);
        check("wake_request", w, wake_request);
        @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check("pslverr", e[32], pslverr);
            if (!pwrite) check("prdata", e[31:0], prdata);
        end
    end
    task summarize;
        if (exp_q.size() != 0) mismatches++;
        if (mismatches == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #100us;
        mismatches++;
        summarize();
    end
    // ****
    // scenarios
    // ****
    initial begin
        {presetn, psel, penable, pwrite, prog_mode, paddr, pwdata} = '0;
        {pfo, pfi, pod, ext2, ext3} = '0;
        void'($urandom(47325));
        ext1 = $urandom;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`TPG_IDX_OPTION, 8'hff);
        rd(`TPG_IDX_FIRST_DIR, 8'h3f);
        rd(`TPG_IDX_ANALOG_CFG, 8'h00);
        rd(`TPG_IDX_FIRST_DATA, {3'b000, ext1[4], 4'h0});
        acc(1'b0, 12'h3fc, 32'h0000_0000, {1'b1, 32'h0000_0000});
        acc(1'b1, 12'h219, 32'h0000_0000, {1'b1, 32'h0000_0000});
        rd(`TPG_IDX_SECOND_DIR, 8'hff);
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            l = $urandom;
            o = $urandom;
            ext2 <= $urandom;
            prog_mode <= $urandom;
            wr(`TPG_IDX_SECOND_DATA, l);
            wr(`TPG_IDX_SECOND_DIR, d);
            wr(`TPG_IDX_OPTION, o);
            check("second_oe_n", d, second_port_pad.oe_n);
            check("second_out", l & ~d, second_port_pad.out & ~d);
            check("pullup_en", o[7] ? 8'h00 : d, second_port_pullup_en);
            v = (~d & l) | (d & (o[7] ? ext2 : 8'hff));
            check("alt_pins", {prog_mode & v[7], prog_mode & v[6], v[0]}, {pdat_o, pclk_o, eint});
            rd(`TPG_IDX_SECOND_DATA, v);
        end
        wr(`TPG_IDX_SECOND_DIR, 8'hff);
        wr(`TPG_IDX_OPTION, 8'hff);
        v = $urandom;
        ext2 <= v;
        rd(`TPG_IDX_SECOND_DATA, v);
        wr(`TPG_IDX_INT_CTRL, 8'h08);
        flag_is(1'b0, 1'b0);
        ext2 <= v ^ 8'h02;
        flag_is(1'b0, 1'b0);
        ext2 <= v ^ 8'h22;
        flag_is(1'b1, 1'b1);
        wr(`TPG_IDX_INT_CTRL, 8'h08);
        flag_is(1'b1, 1'b1);
        rd(`TPG_IDX_INT_CTRL, 8'h09);
        rd(`TPG_IDX_SECOND_DATA, v ^ 8'h22);
        wr(`TPG_IDX_INT_CTRL, 8'h08);
        flag_is(1'b0, 1'b0);
        ext2 <= v ^ 8'ha2;
        flag_is(1'b1, 1'b1);
        wr(`TPG_IDX_SECOND_DATA, 8'h00);
        wr(`TPG_IDX_INT_CTRL, 8'h08);
        flag_is(1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            l = $urandom;
            o = $urandom;
            pfo <= 8'($urandom) & 8'($urandom);
            pfi <= $urandom;
            pod <= $urandom;
            ext3 <= $urandom;
            wr(`TPG_IDX_THIRD_DATA, l);
            wr(`TPG_IDX_THIRD_DIR, d);
            eff = ~pfo & (pfi | d);
            check("third_oe_n", eff, third_port_pad.oe_n);
            check("third_out", ((pfo & pod) | (~pfo & l)) & ~eff, third_port_pad.out & ~eff);
            rd(`TPG_IDX_THIRD_DIR, eff);
            rd(`TPG_IDX_THIRD_DATA, (eff & ext3) | (~eff & ((pfo & pod) | (~pfo & l))));
        end
        ext1 <= $urandom;
        l = $urandom;
        wr(`TPG_IDX_ANALOG_CFG, 8'h06);
        rd(`TPG_IDX_ANALOG_CFG, 8'h06);
        check("analog_sel", 6'h00, first_port_analog_sel);
        wr(`TPG_IDX_FIRST_DIR, 8'hff);
        rd(`TPG_IDX_FIRST_DIR, 8'h3f);
        wr(`TPG_IDX_FIRST_DATA, l);
        rd(`TPG_IDX_FIRST_DATA, {2'b00, ext1[5:0]});
        wr(`TPG_IDX_FIRST_DIR, 8'h00);
        check("first_oe_n", {2'b11, 1'b0, l[4], 4'h0}, first_port_pad.oe_n);
        rd(`TPG_IDX_FIRST_DATA, {2'b00, l[5], l[4] & ext1[4], l[3:0]});
        summarize();
    end
endmodule
